// *** iorm_ext_cycle.v ***
// External read and write cycle sequencer driving the port C and D bus lines
// Assumes the data input is already synchronised by the caller
`timescale 1ns/1ps
`include "iorm_map.vh"

module iorm_ext_cycle #(
   parameter STRB_CYC = `IORM_STRB_CYC
) (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire start,
   input wire wr,
   input wire [15:0] addr,
   input wire [7:0] wrData,
   input wire muxMode,
   input wire [7:0] pdIn,
   output reg [7:0] pcBus_q,
   output reg [7:0] pdOut_q,
   output reg [7:0] pdOeN_q,
   output reg done_q,
   output reg [7:0] rdData_q
);

   localparam S_IDLE = 4'b0001;
   localparam S_ADDR = 4'b0010;
   localparam S_STRB = 4'b0100;
   localparam S_HOLD = 4'b1000;
   localparam integer STRB_LAST_I = STRB_CYC - 1;
   localparam [`IORM_STRB_W-1:0] STRB_LAST = STRB_LAST_I[`IORM_STRB_W-1:0];
   localparam [`IORM_STRB_W-1:0] CNT_ONE = {{(`IORM_STRB_W-1){1'b0}}, 1'b1};

   reg [3:0] state_q;
   reg [`IORM_STRB_W-1:0] cnt_q;
   reg wr_q;
   reg [15:0] addr_q;
   reg [7:0] wd_q;

   // Port C word: A0-A3, A12, read/write, A13, memory select (low active)
   function [7:0] pcWord;
      input [15:0] a;
      input w;
      input selN;
      begin
         pcWord = {selN, a[13], ~w, a[12], a[3:0]};
      end
   endfunction

   always @(posedge clk_sys) begin
      if (rst) begin
         state_q <= S_IDLE;
         cnt_q <= {`IORM_STRB_W{1'b0}};
         wr_q <= 1'b0;
         addr_q <= `IORM_WORD_ZERO;
         wd_q <= `IORM_BYTE_ZERO;
         pcBus_q <= `IORM_PC_IDLE;
         pdOut_q <= `IORM_BYTE_ZERO;
         pdOeN_q <= `IORM_BYTE_ONES;
         done_q <= 1'b0;
         rdData_q <= `IORM_BYTE_ZERO;
      end else if (ce) begin
         done_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  wr_q <= wr;
                  addr_q <= addr;
                  wd_q <= wrData;
                  pcBus_q <= pcWord(addr, wr, 1'b1);
                  // Multiplexed mode puts A4-A11 on port D first
                  pdOut_q <= muxMode ? addr[11:4] : `IORM_BYTE_ZERO;
                  pdOeN_q <= muxMode ? `IORM_BYTE_ZERO : `IORM_BYTE_ONES;
                  state_q <= S_ADDR;
               end
            end
            S_ADDR: begin
               pcBus_q <= pcWord(addr_q, wr_q, 1'b0);
               pdOut_q <= wd_q;
               pdOeN_q <= wr_q ? `IORM_BYTE_ZERO : `IORM_BYTE_ONES;
               cnt_q <= {`IORM_STRB_W{1'b0}};
               state_q <= S_STRB;
            end
            S_STRB: begin
               if (cnt_q == STRB_LAST) begin
                  rdData_q <= pdIn;
                  pcBus_q <= pcWord(addr_q, wr_q, 1'b1);
                  state_q <= S_HOLD;
               end else begin
                  cnt_q <= cnt_q + CNT_ONE;
               end
            end
            S_HOLD: begin
               pcBus_q <= `IORM_PC_IDLE;
               pdOeN_q <= `IORM_BYTE_ONES;
               done_q <= 1'b1;
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

endmodule

// *** iorm_ext_mem.sv ***
// Sixteen-byte external memory on the port C and D expansion bus
// Assumes pull-ups on port C only; port D floats when nobody drives
`timescale 1ns/1ps
module iorm_ext_mem (
   input wire clk_sys,
   input wire [7:0] pcOut,
   input wire [7:0] pcOeN,
   input wire [7:0] pdOut,
   input wire [7:0] pdOeN,
   output wire [7:0] pcPins,
   output wire [7:0] pdPins
);
   reg [7:0] mem [0:15];
   reg [7:0] lastPd = 8'h00;
   integer i;
   wire sel = ~pcPins[7];
   wire rdCyc = pcPins[5];
   wire [3:0] a = pcPins[3:0];
   wire [7:0] drv = (sel && rdCyc) ? mem[a] : ~lastPd;
   assign pcPins = pcOut | pcOeN;
   assign pdPins = (~pdOeN & pdOut) | (pdOeN & drv);
   initial begin
      for (i = 0; i < 16; i = i + 1) begin
         mem[i] = 8'h00;
      end
   end
   always @(posedge clk_sys) begin
      lastPd <= pdPins;
      if (sel && !rdCyc && pdOeN == 8'h00) begin
         mem[a] <= pdOut;
      end
   end
endmodule

// *** iorm_io_decode.v ***
// I/O page register decode, counter latches and port C/D bus mode mux
// Assumes a CPU-side request port on clk_sys and pins with pull-ups
`timescale 1ns/1ps
`include "iorm_map.vh"

// Notes on behaviour
// - Write 0x1A: upper latch A, load counter A, clear flag; 0x19 latch only
// - Write 0x1E: upper latch B, load counter B from latch, clear flag
// - Write 0x1D: upper latch B and copy latch B to latch C; 0x1C low
// - Per counter: low read that clears its flag, high read, low read
// - Offset 0x17 reads receive data and writes transmit data
// - Serial status fully readable; writes change only bits 4 and 5
// - Offset 0x10 reads all ones; written zeros clear flags 0 to 3
// - Offsets 0x04 to 0x0F run external read or write bus cycles in abbreviated and multiplexed modes
// - Port D carries data (abbreviated) or address then data (multiplexed)
// - Port C carries A0-A3, A12, read/write, A13, memory select in bus modes
// - Full address mode: port C pins 6, 7 give A13, A14; rest stay I/O
// - Mode bits 7..5 = 101 abbreviated, 111 multiplexed
module iorm_io_decode #(
   parameter STRB_CYC = `IORM_STRB_CYC
) (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire cpuReq,
   input wire cpuWr,
   input wire [15:0] cpuAddr,
   input wire [7:0] cpuWrData,
   output reg [7:0] cpuRdData_q,
   output reg cpuAck_q,
   output reg cpuBusy_q,
   input wire [3:0] edgeEvent,
   input wire cntEnA,
   input wire cntEnB,
   input wire [7:0] serRxData,
   input wire [7:0] serStatIn,
   input wire serRxIrq,
   input wire serTxIrq,
   output reg [7:0] serTxData_q,
   output reg serTxLoad_q,
   output reg [7:0] serCtl_q,
   output reg [7:0] irqEn_q,
   output reg [7:0] modeCtl_q,
   output reg [15:0] latchC_q,
   input wire [7:0] portaPinsIn,
   output reg [7:0] portaPinsOut_q,
   output reg [7:0] portaPinsOeN_q,
   input wire [7:0] portbPinsIn,
   output reg [7:0] portbPinsOut_q,
   output reg [7:0] portbPinsOeN_q,
   input wire [7:0] portcPinsIn,
   output reg [7:0] portcPinsOut_q,
   output reg [7:0] portcPinsOeN_q,
   input wire [7:0] portdPinsIn,
   output reg [7:0] portdPinsOut_q,
   output reg [7:0] portdPinsOeN_q
);

   reg [7:0] portA_q;
   reg [7:0] portB_q;
   reg [7:0] portC_q;
   reg [7:0] portD_q;
   reg [3:0] flagEdge_q;
   reg flagCntA_q;
   reg flagCntB_q;
   reg [1:0] stat45_q;
   reg [15:0] latchA_q;
   reg [15:0] cntA_q;
   reg [15:0] latchB_q;
   reg [15:0] cntB_q;
   reg [31:0] syncA_q;
   reg [31:0] syncB_q;
   reg [31:0] syncC_q;
   reg [31:0] pinIn_q;
   reg [7:0] rdMux;

   wire [4:0] off = cpuAddr[4:0];
   wire [2:0] busMode = modeCtl_q[`IORM_MODE_HI:`IORM_MODE_LO];
   wire modeAbb = (busMode == `IORM_MODE_ABB);
   wire modeMux = (busMode == `IORM_MODE_MUX);
   wire modeFull = (busMode == `IORM_MODE_FULL);
   wire busOn = modeAbb | modeMux;
   wire take = cpuReq & ~cpuBusy_q;
   wire takeWr = take & cpuWr;
   wire takeRd = take & ~cpuWr;
   wire extHit = isExt(off);
   wire extStart = take & extHit & busOn;
   wire [7:0] extPc;
   wire [7:0] extPdOut;
   wire [7:0] extPdOeN;
   wire extDone;
   wire [7:0] extRdData;
   wire [16:0] nxtA;
   wire [16:0] nxtB;
   wire clrA;
   wire clrB;
   wire [3:0] clrEdge;
   wire [31:0] syncEq;
   wire [7:0] flagsRd;
   wire [7:0] statRd;

   // Offsets that belong to the external bus
   function isExt;
      input [4:0] a;
      begin
         isExt = (a >= `IORM_EXT_LO) && (a <= `IORM_EXT_HI);
      end
   endfunction

   // Down count with reload from latch on underflow; top bit flags underflow
   function [16:0] cntNext;
      input [15:0] cnt;
      input [15:0] lat;
      input en;
      begin
         if (!en) begin
            cntNext = {1'b0, cnt};
         end else if (cnt == `IORM_WORD_ZERO) begin
            cntNext = {1'b1, lat};
         end else begin
            cntNext = {1'b0, cnt - 16'h0001};
         end
      end
   endfunction

   assign nxtA = cntNext(cntA_q, latchA_q, cntEnA);
   assign nxtB = cntNext(cntB_q, latchB_q, cntEnB);
   // Flag clears by load writes and by clearing reads
   assign clrA = (takeWr & (off == `IORM_CNTA_LO_LOAD))
      | (takeRd & (off == `IORM_CNTA_LO_CLR));
   assign clrB = (takeWr & (off == `IORM_CNTB_LO_LOAD))
      | (takeRd & (off == `IORM_CNTB_LO_CLR));
   assign clrEdge = (takeWr & (off == `IORM_FLAG_CLR)) ?
      ~cpuWrData[3:0] : 4'h0;
   assign flagsRd = {serTxIrq, serRxIrq, flagCntB_q, flagCntA_q, flagEdge_q};
   assign statRd = {serStatIn[7:6], stat45_q, serStatIn[3:0]};
   assign syncEq = ~(syncB_q ^ syncC_q);

   iorm_ext_cycle #(
      .STRB_CYC(STRB_CYC)
   ) u_ext (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .start(extStart),
      .wr(cpuWr),
      .addr(cpuAddr),
      .wrData(cpuWrData),
      .muxMode(modeMux),
      .pdIn(pinIn_q[31:24]),
      .pcBus_q(extPc),
      .pdOut_q(extPdOut),
      .pdOeN_q(extPdOeN),
      .done_q(extDone),
      .rdData_q(extRdData)
   );

   // Read data for internal locations
   always @* begin
      rdMux = `IORM_UNUSED_RD;
      case (off)
         `IORM_PORTA: rdMux = pinIn_q[7:0];
         `IORM_PORTB: rdMux = pinIn_q[15:8];
         `IORM_PORTC: rdMux = pinIn_q[23:16];
         `IORM_PORTD: rdMux = pinIn_q[31:24];
         `IORM_FLAG_CLR: rdMux = `IORM_READ_FF;
         `IORM_FLAGS: rdMux = flagsRd;
         `IORM_IRQ_EN: rdMux = irqEn_q;
         `IORM_MODE: rdMux = modeCtl_q;
         `IORM_SER_CTL: rdMux = serCtl_q;
         `IORM_SER_STAT: rdMux = statRd;
         `IORM_SER_DATA: rdMux = serRxData;
         `IORM_CNTA_LO_CLR: rdMux = cntA_q[7:0];
         `IORM_CNTA_HI: rdMux = cntA_q[15:8];
         `IORM_CNTA_LO_LOAD: rdMux = cntA_q[7:0];
         `IORM_CNTB_LO_CLR: rdMux = cntB_q[7:0];
         `IORM_CNTB_HI_COPY: rdMux = cntB_q[15:8];
         `IORM_CNTB_LO_LOAD: rdMux = cntB_q[7:0];
         default: rdMux = `IORM_UNUSED_RD;
      endcase
   end

   // Pin input synchroniser; a change counts once stages two and three agree
   always @(posedge clk_sys) begin
      if (rst) begin
         syncA_q <= 32'h00000000;
         syncB_q <= 32'h00000000;
         syncC_q <= 32'h00000000;
         pinIn_q <= 32'h00000000;
      end else if (ce) begin
         syncA_q <= {portdPinsIn, portcPinsIn, portbPinsIn, portaPinsIn};
         syncB_q <= syncA_q;
         syncC_q <= syncB_q;
         pinIn_q <= (syncB_q & syncEq) | (pinIn_q & ~syncEq);
      end
   end

   // Register file, counters and request handling
   always @(posedge clk_sys) begin
      if (rst) begin
         portA_q <= `IORM_BYTE_ONES;
         portB_q <= `IORM_BYTE_ONES;
         portC_q <= `IORM_BYTE_ONES;
         portD_q <= `IORM_BYTE_ONES;
         flagEdge_q <= 4'h0;
         flagCntA_q <= 1'b0;
         flagCntB_q <= 1'b0;
         stat45_q <= 2'b00;
         latchA_q <= `IORM_WORD_ZERO;
         cntA_q <= `IORM_WORD_ZERO;
         latchB_q <= `IORM_WORD_ZERO;
         cntB_q <= `IORM_WORD_ZERO;
         latchC_q <= `IORM_WORD_ZERO;
         serTxData_q <= `IORM_BYTE_ZERO;
         serTxLoad_q <= 1'b0;
         serCtl_q <= `IORM_BYTE_ZERO;
         irqEn_q <= `IORM_BYTE_ZERO;
         modeCtl_q <= `IORM_BYTE_ZERO;
         cpuRdData_q <= `IORM_BYTE_ZERO;
         cpuAck_q <= 1'b0;
         cpuBusy_q <= 1'b0;
      end else if (ce) begin
         cpuAck_q <= 1'b0;
         serTxLoad_q <= 1'b0;
         cntA_q <= nxtA[15:0];
         cntB_q <= nxtB[15:0];
         // Set wins over a clear in the same cycle
         flagEdge_q <= edgeEvent | (flagEdge_q & ~clrEdge);
         flagCntA_q <= nxtA[16] | (flagCntA_q & ~clrA);
         flagCntB_q <= nxtB[16] | (flagCntB_q & ~clrB);
         if (extDone) begin
            cpuRdData_q <= extRdData;
            cpuAck_q <= 1'b1;
            cpuBusy_q <= 1'b0;
         end
         if (extStart) begin
            cpuBusy_q <= 1'b1;
         end else if (take) begin
            cpuAck_q <= 1'b1;
            cpuRdData_q <= cpuWr ? `IORM_BYTE_ZERO : rdMux;
            if (extHit) begin
               cpuRdData_q <= `IORM_UNUSED_RD;
            end
         end
         if (takeWr & ~extHit) begin
            case (off)
               `IORM_PORTA: portA_q <= cpuWrData;
               `IORM_PORTB: portB_q <= cpuWrData;
               `IORM_PORTC: portC_q <= cpuWrData;
               `IORM_PORTD: portD_q <= cpuWrData;
               `IORM_IRQ_EN: irqEn_q <= cpuWrData;
               `IORM_MODE: modeCtl_q <= cpuWrData;
               `IORM_SER_CTL: serCtl_q <= cpuWrData;
               `IORM_SER_STAT: begin
                  stat45_q <= cpuWrData[5:4];
               end
               `IORM_SER_DATA: begin
                  serTxData_q <= cpuWrData;
                  serTxLoad_q <= 1'b1;
               end
               `IORM_CNTA_LO_CLR: latchA_q[7:0] <= cpuWrData;
               `IORM_CNTA_HI: latchA_q[15:8] <= cpuWrData;
               `IORM_CNTA_LO_LOAD: begin
                  latchA_q[15:8] <= cpuWrData;
                  cntA_q <= {cpuWrData, latchA_q[7:0]};
               end
               `IORM_CNTB_LO_CLR: latchB_q[7:0] <= cpuWrData;
               `IORM_CNTB_HI_COPY: begin
                  latchB_q[15:8] <= cpuWrData;
                  latchC_q <= {cpuWrData, latchB_q[7:0]};
               end
               `IORM_CNTB_LO_LOAD: begin
                  latchB_q[15:8] <= cpuWrData;
                  cntB_q <= {cpuWrData, latchB_q[7:0]};
               end
               default: begin
                  latchC_q <= latchC_q;
               end
            endcase
         end
      end
   end

   // Pin drive; I/O bits drive low and release high onto the pull-up
   always @(posedge clk_sys) begin
      if (rst) begin
         portaPinsOut_q <= `IORM_BYTE_ONES;
         portaPinsOeN_q <= `IORM_BYTE_ONES;
         portbPinsOut_q <= `IORM_BYTE_ONES;
         portbPinsOeN_q <= `IORM_BYTE_ONES;
         portcPinsOut_q <= `IORM_BYTE_ONES;
         portcPinsOeN_q <= `IORM_BYTE_ONES;
         portdPinsOut_q <= `IORM_BYTE_ONES;
         portdPinsOeN_q <= `IORM_BYTE_ONES;
      end else if (ce) begin
         portaPinsOut_q <= portA_q;
         portaPinsOeN_q <= portA_q;
         portbPinsOut_q <= portB_q;
         portbPinsOeN_q <= portB_q;
         if (busOn) begin
            portcPinsOut_q <= extPc;
            portcPinsOeN_q <= `IORM_BYTE_ZERO;
            portdPinsOut_q <= extPdOut;
            portdPinsOeN_q <= extPdOeN;
         end else if (modeFull) begin
            portcPinsOut_q <= {cpuAddr[14], cpuAddr[13], portC_q[5:0]};
            portcPinsOeN_q <= {2'b00, portC_q[5:0]};
            portdPinsOut_q <= portD_q;
            portdPinsOeN_q <= portD_q;
         end else begin
            portcPinsOut_q <= portC_q;
            portcPinsOeN_q <= portC_q;
            portdPinsOut_q <= portD_q;
            portdPinsOeN_q <= portD_q;
         end
      end
   end

endmodule

// *** iorm_io_decode_checker.sv ***
// Concurrent checks on the I/O page decode ports
// Assumes a bind onto iorm_io_decode and a single clk_sys domain
`timescale 1ns/1ps
module iorm_io_decode_checker (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire cpuReq,
   input wire cpuWr,
   input wire [15:0] cpuAddr,
   input wire [7:0] cpuWrData,
   input wire [7:0] cpuRdData_q,
   input wire cpuAck_q,
   input wire cpuBusy_q,
   input wire [7:0] serTxData_q,
   input wire serTxLoad_q,
   input wire [7:0] modeCtl_q,
   input wire [15:0] latchC_q,
   input wire [7:0] portcPinsOut_q,
   input wire [7:0] portcPinsOeN_q,
   input wire [7:0] portdPinsOeN_q
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   wire take = cpuReq & ~cpuBusy_q & ce;
   wire rdTake = take & ~cpuWr;
   wire wrTake = take & cpuWr;
   wire [4:0] off = cpuAddr[4:0];
   wire ext = off >= 5'h04 && off <= 5'h0f;
   wire [2:0] md = modeCtl_q[7:5];
   wire busMode = md == 3'h5 || md == 3'h7;
   reg [15:0] addr_q;
   reg wr_q;
   always @(posedge clk_sys) begin
      if (take) begin
         addr_q <= cpuAddr;
         wr_q <= cpuWr;
      end
   end
   sequence s_ext_take;
      take && ext && busMode;
   endsequence
   sequence s_ext_run;
      cpuBusy_q ##[1:20] cpuAck_q;
   endsequence
   sequence s_full_hold;
      (md == 3'h3 && $stable(cpuAddr[14:13])) [*3];
   endsequence
   sequence s_abb_idle;
      (md == 3'h5 && !cpuBusy_q) [*3];
   endsequence
   chk_ext_cycle: assert property (s_ext_take |=> s_ext_run)
      else $error("external access ran no bus cycle");
   chk_int_ack: assert property (take && !(ext && busMode) |=>
      cpuAck_q && !cpuBusy_q)
      else $error("internal access not answered next cycle");
   chk_ff_read: assert property (rdTake && off == 5'h10 |=>
      cpuRdData_q == 8'hff)
      else $error("flag clear location did not read all ones");
   chk_unused_rd: assert property (rdTake && (off == 5'h13 ||
      off == 5'h1b || off == 5'h1f) |=> cpuRdData_q == 8'h00)
      else $error("unused location read not fixed");
   chk_tx_load: assert property (wrTake && off == 5'h17 |=>
      serTxLoad_q && serTxData_q == $past(cpuWrData))
      else $error("transmit data not loaded");
   chk_latch_copy: assert property (wrTake && off == 5'h1d |=>
      latchC_q[15:8] == $past(cpuWrData))
      else $error("latch C high byte not copied");
   chk_pin_map: assert property (busMode && !portcPinsOut_q[7] &&
      !portcPinsOeN_q[7] |-> portcPinsOeN_q == 8'h00 &&
      portcPinsOut_q[3:0] == addr_q[3:0] &&
      portcPinsOut_q[4] == addr_q[12] &&
      portcPinsOut_q[6] == addr_q[13] && portcPinsOut_q[5] == !wr_q)
      else $error("port C bus lines wrong during strobe");
   chk_full_addr: assert property (s_full_hold |->
      portcPinsOeN_q[7:6] == 2'h0 &&
      portcPinsOut_q[7:6] == cpuAddr[14:13])
      else $error("full mode high address pins wrong");
   chk_portd_idle: assert property (s_abb_idle |->
      portdPinsOeN_q == 8'hff && portcPinsOut_q[7])
      else $error("port D or select active outside a cycle");
endmodule

bind iorm_io_decode iorm_io_decode_checker chk (.clk_sys(clk_sys),
   .rst(rst), .ce(ce), .cpuReq(cpuReq), .cpuWr(cpuWr),
   .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuRdData_q(cpuRdData_q),
   .cpuAck_q(cpuAck_q), .cpuBusy_q(cpuBusy_q),
   .serTxData_q(serTxData_q), .serTxLoad_q(serTxLoad_q),
   .modeCtl_q(modeCtl_q), .latchC_q(latchC_q),
   .portcPinsOut_q(portcPinsOut_q), .portcPinsOeN_q(portcPinsOeN_q),
   .portdPinsOeN_q(portdPinsOeN_q));

// *** iorm_io_decode_tb.sv ***
// Self-checking bench for the I/O page decode and port C/D bus mux
// Assumes the external memory model on ports C and D
`timescale 1ns/1ps
module iorm_io_decode_tb;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg ce = 1'b1;
   reg cpuReq = 1'b0;
   reg cpuWr = 1'b0;
   reg cntEnA = 1'b0;
   reg cntEnB = 1'b0;
   reg serRxIrq = 1'b0;
   reg serTxIrq = 1'b0;
   reg [15:0] cpuAddr = 16'h0000;
   reg [7:0] cpuWrData = 8'h00;
   reg [7:0] serRxData = 8'h00;
   reg [7:0] serStatIn = 8'h00;
   reg [3:0] edgeEvent = 4'h0;
   wire [7:0] cpuRdData_q, serTxData_q, serCtl_q, irqEn_q, modeCtl_q;
   wire cpuAck_q, cpuBusy_q, serTxLoad_q;
   wire [15:0] latchC_q;
   wire [7:0] paO, paE, pbO, pbE, pcO, pcE, pdO, pdE, pcIn, pdIn;
   integer error_cnt = 0;
   integer cmp_count = 0;
   iorm_io_decode #(.STRB_CYC(8)) dut (.clk_sys(clk_sys), .rst(rst),
      .ce(ce), .cpuReq(cpuReq), .cpuWr(cpuWr), .cpuAddr(cpuAddr),
      .cpuWrData(cpuWrData), .cpuRdData_q(cpuRdData_q),
      .cpuAck_q(cpuAck_q), .cpuBusy_q(cpuBusy_q), .edgeEvent(edgeEvent),
      .cntEnA(cntEnA), .cntEnB(cntEnB), .serRxData(serRxData),
      .serStatIn(serStatIn), .serRxIrq(serRxIrq), .serTxIrq(serTxIrq),
      .serTxData_q(serTxData_q), .serTxLoad_q(serTxLoad_q),
      .serCtl_q(serCtl_q), .irqEn_q(irqEn_q), .modeCtl_q(modeCtl_q),
      .latchC_q(latchC_q), .portaPinsIn(paO | paE), .portaPinsOut_q(paO),
      .portaPinsOeN_q(paE), .portbPinsIn(pbO | pbE),
      .portbPinsOut_q(pbO), .portbPinsOeN_q(pbE), .portcPinsIn(pcIn),
      .portcPinsOut_q(pcO), .portcPinsOeN_q(pcE), .portdPinsIn(pdIn),
      .portdPinsOut_q(pdO), .portdPinsOeN_q(pdE));
   iorm_ext_mem mem (.clk_sys(clk_sys), .pcOut(pcO), .pcOeN(pcE),
      .pdOut(pdO), .pdOeN(pdE), .pcPins(pcIn), .pdPins(pdIn));
   task complete_run;
      begin
         $display("errors %0d compares %0d", error_cnt, cmp_count);
         if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
         end else begin
            $display("DONE - FAIL");
         end
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            $display("Error t=%0t got %h exp %h", $time, got, exp);
            error_cnt = error_cnt + 1;
         end
      end
   endtask
   task bus(input w, input [15:0] a, input [7:0] d, output [7:0] q);
      integer n;
      begin
         @(posedge clk_sys);
         cpuReq <= 1'b1;
         cpuWr <= w;
         cpuAddr <= a;
         cpuWrData <= d;
         @(posedge clk_sys);
         cpuReq <= 1'b0;
         #1;
         n = 0;
         while (cpuAck_q !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
         end
         q = cpuRdData_q;
         if (cpuAck_q !== 1'b1) chk({7'h00, cpuAck_q}, 8'h01);
      end
   endtask
   task rd(input [15:0] a, input [7:0] e);
      reg [7:0] q;
      begin
         bus(1'b0, a, 8'h00, q);
         chk(q, e);
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      reg [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task pulse(input b);
      begin
         @(posedge clk_sys);
         if (b) cntEnB <= 1'b1;
         else cntEnA <= 1'b1;
         @(posedge clk_sys);
         cntEnA <= 1'b0;
         cntEnB <= 1'b0;
      end
   endtask
   task flag(input [2:0] i, input e);
      reg [7:0] q;
      begin
         bus(1'b0, 16'h0011, 8'h00, q);
         chk({7'h00, q[i]}, {7'h00, e});
      end
   endtask
   task test_counter(input b);
      reg [15:0] lo, hi, ld;
      reg [2:0] f;
      begin
         lo = b ? 16'h001c : 16'h0018;
         hi = lo + 16'h0001;
         ld = lo + 16'h0002;
         f = b ? 3'h5 : 3'h4;
         wr(lo, 8'h34);
         wr(hi, 8'h12);
         rd(ld, 8'h00);
         rd(hi, 8'h00);
         if (b) chk(latchC_q[15:8], 8'h12);
         if (b) chk(latchC_q[7:0], 8'h34);
         pulse(b);
         flag(f, 1'b1);
         rd(ld, 8'h34);
         rd(hi, 8'h12);
         flag(f, 1'b1);
         rd(lo, 8'h34);
         flag(f, 1'b0);
         wr(lo, 8'h00);
         wr(ld, 8'h00);
         pulse(b);
         flag(f, 1'b1);
         wr(lo, 8'h78);
         wr(ld, 8'h56);
         flag(f, 1'b0);
         rd(ld, 8'h78);
         rd(hi, 8'h56);
      end
   endtask
   task test_serial;
      begin
         serRxData <= 8'h3c;
         wr(16'h0017, 8'ha5);
         chk({7'h00, serTxLoad_q}, 8'h01);
         chk(serTxData_q, 8'ha5);
         rd(16'h0017, 8'h3c);
         serStatIn <= 8'h00;
         wr(16'h0016, 8'hff);
         rd(16'h0016, 8'h30);
         serStatIn <= 8'hff;
         wr(16'h0016, 8'h00);
         rd(16'h0016, 8'hcf);
      end
   endtask
   task test_flags;
      begin
         @(posedge clk_sys);
         serRxIrq <= 1'b1;
         edgeEvent <= 4'hf;
         @(posedge clk_sys);
         edgeEvent <= 4'h0;
         rd(16'h0011, 8'h4f);
         wr(16'h0010, 8'hfa);
         rd(16'h0011, 8'h4a);
         rd(16'h0010, 8'hff);
         wr(16'h0010, 8'h00);
         rd(16'h0011, 8'h40);
         serRxIrq <= 1'b0;
      end
   endtask
   task test_unused;
      reg [19:0] list;
      integer i;
      begin
         list = {5'h11, 5'h13, 5'h1b, 5'h1f};
         for (i = 0; i < 4; i = i + 1) begin
            wr({11'h000, list[i*5+:5]}, 8'hff);
         end
         for (i = 0; i < 4; i = i + 1) begin
            rd({11'h000, list[i*5+:5]}, 8'h00);
         end
      end
   endtask
   task test_modes;
      begin
         wr(16'h0014, 8'he0);
         wr(16'h2fe5, 8'hc3);
         wr(16'h0014, 8'ha0);
         chk(pcE, 8'h00);
         chk(pdE, 8'hff);
         wr(16'h100a, 8'h77);
         rd(16'h3005, 8'hc3);
         rd(16'h000a, 8'h77);
         wr(16'h0014, 8'h60);
         rd(16'h6012, 8'h00);
         repeat (3) @(posedge clk_sys);
         #1;
         chk(pcE, 8'h3f);
         chk({6'h00, pcO[7:6]}, 8'h03);
         chk(pdE, 8'hff);
         rd(16'h0005, 8'h00);
         wr(16'h0014, 8'h00);
         repeat (3) @(posedge clk_sys);
         #1;
         chk(pcE, 8'hff);
      end
   endtask
   task test_regs;
      begin
         wr(16'h0015, 8'h5a);
         wr(16'h0012, 8'ha5);
         wr(16'h0000, 8'h0f);
         wr(16'h0001, 8'hf0);
         chk(serCtl_q, 8'h5a);
         chk(irqEn_q, 8'ha5);
         rd(16'h0015, 8'h5a);
         rd(16'h0012, 8'ha5);
         chk(paE, 8'h0f);
         chk(pbO, 8'hf0);
         rd(16'h0000, 8'h0f);
         rd(16'h0001, 8'hf0);
      end
   endtask
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      complete_run;
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      rd(16'h0014, 8'h00);
      test_counter(1'b0);
      test_counter(1'b1);
      test_serial;
      test_flags;
      test_unused;
      test_modes;
      test_regs;
      complete_run;
   end
endmodule

// *** iorm_map.vh ***
// Offsets, field positions, reset values and timing of the I/O page decode
// Assumes a five-bit register offset within the page
`ifndef IORM_MAP_VH
`define IORM_MAP_VH

// Register offsets
`define IORM_PORTA 5'h00
`define IORM_PORTB 5'h01
`define IORM_PORTC 5'h02
`define IORM_PORTD 5'h03
`define IORM_EXT_LO 5'h04
`define IORM_EXT_HI 5'h0f
`define IORM_FLAG_CLR 5'h10
`define IORM_FLAGS 5'h11
`define IORM_IRQ_EN 5'h12
`define IORM_UNUSED13 5'h13
`define IORM_MODE 5'h14
`define IORM_SER_CTL 5'h15
`define IORM_SER_STAT 5'h16
`define IORM_SER_DATA 5'h17
`define IORM_CNTA_LO_CLR 5'h18
`define IORM_CNTA_HI 5'h19
`define IORM_CNTA_LO_LOAD 5'h1a
`define IORM_UNUSED1B 5'h1b
`define IORM_CNTB_LO_CLR 5'h1c
`define IORM_CNTB_HI_COPY 5'h1d
`define IORM_CNTB_LO_LOAD 5'h1e
`define IORM_UNUSED1F 5'h1f

// Bus mode field in the mode control register, read as {bit7, bit6, bit5}
`define IORM_MODE_HI 7
`define IORM_MODE_LO 5
`define IORM_MODE_ABB 3'h5
`define IORM_MODE_MUX 3'h7
`define IORM_MODE_FULL 3'h3

// Field masks and fixed read values
`define IORM_STAT_WR_MASK 8'h30
`define IORM_READ_FF 8'hff
`define IORM_UNUSED_RD 8'h00
`define IORM_BYTE_ZERO 8'h00
`define IORM_BYTE_ONES 8'hff
`define IORM_WORD_ZERO 16'h0000
`define IORM_PC_IDLE 8'ha0

// External cycle strobe length in clock cycles
`define IORM_STRB_CYC 8
`define IORM_STRB_W 4

`endif
